// ==== fpcc_params.svh ====
/*
 * Constants of the clock-generation control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by bare name, after any timescale directive.
 */
`ifndef FPCC_PARAMS_SVH
`define FPCC_PARAMS_SVH

// Register byte offsets on the APB window
`define FPCC_ADDR_FLL_CTRL 8'h00
`define FPCC_ADDR_PLL_CTRLB 8'h04
`define FPCC_ADDR_PLL_RATIO 8'h08
`define FPCC_ADDR_IRQ_FLAGS 8'h0C
`define FPCC_ADDR_PLL_STATUS 8'h10
`define FPCC_ADDR_XOSC_CTRL 8'h14
`define FPCC_ADDR_PWR_STATUS 8'h18

// Frequency-locked loop control fields
`define FPCC_FLL_EN_BIT 0
`define FPCC_FLL_ONREQ_BIT 1
`define FPCC_FLL_CTRL_RST 2'h2

// Phase-locked loop control B fields
`define FPCC_LTSEL_LSB 0
`define FPCC_LTSEL_MSB 2
`define FPCC_BYPASS_BIT 3
`define FPCC_PLL_EN_BIT 4
`define FPCC_PLL_CTRLB_RST 5'h00

// Ratio register
`define FPCC_RATIO_W 16
`define FPCC_RATIO_RST 16'h0000

// Interrupt flag positions
`define FPCC_IRQ_W 6
`define FPCC_IRQ_FLL_COARSE 0
`define FPCC_IRQ_FLL_FINE 1
`define FPCC_IRQ_FLL_OOB 2
`define FPCC_IRQ_LOCK_RISE 3
`define FPCC_IRQ_LOCK_FALL 4
`define FPCC_IRQ_RATIO_DONE 5

// Crystal oscillator control
`define FPCC_AAMP_BIT 0

// Calibration limits
`define FPCC_COARSE_W 6
`define FPCC_FINE_W 10
`define FPCC_COARSE_MAX 6'h3F
`define FPCC_FINE_MAX 10'h3FF

// Timing: clock rate and lock time-outs
`define FPCC_CLK_MHZ 100
`define FPCC_TO_SHORT_MS 10
`define FPCC_TO_LONG_MS 11
`define FPCC_TO_SHORT_CYC (`FPCC_TO_SHORT_MS * 1000 * `FPCC_CLK_MHZ)
`define FPCC_TO_LONG_CYC (`FPCC_TO_LONG_MS * 1000 * `FPCC_CLK_MHZ)
`define FPCC_TO_CNT_W 21

`endif

// ==== fpcc_pkg.sv ====
/*
 * Types of the clock-generation control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpcc_pkg;
   // Ratio update tracking states
   typedef enum logic [0:0] {
      FPCC_RATIO_IDLE = 1'b0, // No update outstanding
      FPCC_RATIO_WAIT = 1'b1  // New ratio sent, waiting for the loop
   } fpcc_ratio_st_t;
endpackage : fpcc_pkg

// ==== fpcc_timer_if.sv ====
/*
 * Carrier between the control top and its lock time-out timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface fpcc_timer_if;
   logic run;       // Loop enabled and not yet locked
   logic [2:0] sel; // Time-out selector
   logic timeout;   // One-cycle pulse at expiry
   modport ctrl (output run, output sel, input timeout);
   modport timer (input run, input sel, output timeout);
endinterface : fpcc_timer_if
`default_nettype wire

// ==== fpcc_lock_timer.sv ====
/*
 * Lock time-out timer of the phase-locked loop.
 * Assumes run and sel are synchronous to i_clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpcc_params.svh"
module fpcc_lock_timer #(
   parameter int unsigned SHORT_CYC = `FPCC_TO_SHORT_CYC, // Cycles of the short time-out
   parameter int unsigned LONG_CYC = `FPCC_TO_LONG_CYC    // Cycles of the long time-out
) (
   input wire logic i_clock,  // System clock
   input wire logic i_rst,    // Asynchronous reset, active high
   fpcc_timer_if.timer tif    // Run, selector and expiry
);
   logic [`FPCC_TO_CNT_W-1:0] count_q, count_d; // Elapsed cycles
   logic fired_q, fired_d;                       // Expiry seen this run
   logic pulse_q, pulse_d;                       // Expiry pulse

   // Terminal count for a selector; codes below 4 have no time-out
   function automatic logic [`FPCC_TO_CNT_W-1:0] limit_of(input logic [2:0] sel);
      limit_of = sel[1] ? `FPCC_TO_CNT_W'(LONG_CYC - 1) : `FPCC_TO_CNT_W'(SHORT_CYC - 1);
   endfunction : limit_of

   // Next count and expiry
   always_comb begin
      count_d = count_q;
      fired_d = fired_q;
      pulse_d = 1'b0;
      if (!(tif.run && tif.sel[2])) begin
         count_d = '0;
         fired_d = 1'b0;
      end else if (!fired_q) begin
         if (count_q == limit_of(tif.sel)) begin
            fired_d = 1'b1;
            pulse_d = 1'b1;
         end else begin
            count_d = count_q + `FPCC_TO_CNT_W'(1);
         end
      end
   end

   // Registers
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         count_q <= '0;
         fired_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         count_q <= count_d;
         fired_q <= fired_d;
         pulse_q <= pulse_d;
      end
   end

   assign tif.timeout = pulse_q;

   a_timeout_at_limit: assert property (@(posedge i_clock) disable iff (i_rst)
      tif.timeout |-> $past(count_q) == limit_of($past(tif.sel)) && $past(tif.sel[2]))
      else $error("Time-out fired at the wrong count");

   c_timeout_seen: cover property (@(posedge i_clock) disable iff (i_rst) tif.timeout);
endmodule : fpcc_lock_timer
`default_nettype wire

// ==== fpcc_clock_ctrl.sv ====
/*
 * Clock-generation control: frequency-locked loop flags, phase-locked
 * loop lock masking, time-out and ratio loading, crystal amplitude bit,
 * all behind an APB slave.
 * Assumes loop status inputs are synchronous to i_clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpcc_params.svh"
module fpcc_clock_ctrl #(
   parameter int unsigned SHORT_CYC = `FPCC_TO_SHORT_CYC, // Short lock time-out cycles
   parameter int unsigned LONG_CYC = `FPCC_TO_LONG_CYC    // Long lock time-out cycles
) (
   input wire logic i_clock,                          // 100 MHz system clock
   input wire logic i_rst,                            // Asynchronous reset, high
   input wire logic i_psel,                           // APB select
   input wire logic i_penable,                        // APB enable
   input wire logic i_pwrite,                         // APB direction
   input wire logic [7:0] i_paddr,                    // APB byte address
   input wire logic [31:0] i_pwdata,                  // APB write data
   output logic o_pready,                             // APB ready
   output logic [31:0] o_prdata,                      // APB read data
   output logic o_pslverr,                            // APB error
   input wire logic i_pll_lock,                       // Lock detector
   input wire logic i_pll_ratio_applied,              // Loop took new ratio
   input wire logic i_fll_locking,                    // Locking sequence active
   input wire logic i_fll_coarse_lock,                // Coarse lock reached
   input wire logic i_fll_fine_lock,                  // Fine lock reached
   input wire logic [`FPCC_COARSE_W-1:0] i_fll_coarse, // Coarse calibration
   input wire logic [`FPCC_FINE_W-1:0] i_fll_fine,     // Fine calibration
   output logic o_pll_enable,                         // Loop enable
   output logic o_pll_clk_en,                         // Loop output gate
   output logic [`FPCC_RATIO_W-1:0] o_pll_ratio,      // Ratio to the loop
   output logic o_fll_enable,                         // Loop enable
   output logic o_fll_on_request_run,                 // Run only on request
   output logic o_auto_amplitude_en                   // Crystal amplitude control
);
   fpcc_timer_if tif ();                                // Link to the timer

   logic pready_q, pready_d;                            // Answer flag
   logic [31:0] prdata_q, prdata_d;                     // Read data
   logic pslverr_q, pslverr_d;                          // Error flag
   logic [1:0] fll_ctrl_q, fll_ctrl_d;                  // Loop control
   logic [4:0] pll_ctrlb_q, pll_ctrlb_d;                // Control B
   logic [`FPCC_RATIO_W-1:0] ratio_q, ratio_d;          // Ratio
   logic [`FPCC_IRQ_W-1:0] flags_q, flags_d;            // Sticky flags
   logic aamp_q, aamp_d;                                // Amplitude bit
   logic lock_q, lock_d;                                // Lock status
   logic coarse_q, coarse_d;                            // Coarse lock seen
   logic fine_q, fine_d;                                // Fine lock seen
   logic timed_out_q, timed_out_d;                      // Time-out status
   logic clk_en_q, clk_en_d;                            // Output gate
   fpcc_pkg::fpcc_ratio_st_t rst_q, rst_d;              // Ratio tracker
   logic access;                                        // Access phase, first cycle
   logic wr;                                            // Write commits
   logic mapped;                                        // Address decodes
   logic [`FPCC_IRQ_W-1:0] set;                         // Hardware set terms
   logic [`FPCC_IRQ_W-1:0] clr;                         // Software clear terms

   // True when a calibration value sits at zero or full scale
   function automatic logic at_limit(input logic [9:0] val, input logic [9:0] max);
      at_limit = (val == 10'h000) || (val == max);
   endfunction : at_limit

   // Lock time-out timer
   fpcc_lock_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) fpcc_lock_timer_i (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .tif(tif)
   );
   assign tif.run = pll_ctrlb_q[`FPCC_PLL_EN_BIT] && !lock_q;
   assign tif.sel = pll_ctrlb_q[`FPCC_LTSEL_MSB:`FPCC_LTSEL_LSB];

   // Bus decode: answer one cycle into the access phase
   always_comb begin
      access = i_psel && i_penable && !pready_q;
      wr = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
      unique case (i_paddr)
         `FPCC_ADDR_FLL_CTRL, `FPCC_ADDR_PLL_CTRLB, `FPCC_ADDR_PLL_RATIO,
         `FPCC_ADDR_IRQ_FLAGS, `FPCC_ADDR_PLL_STATUS, `FPCC_ADDR_XOSC_CTRL,
         `FPCC_ADDR_PWR_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Bus answer and read mux
   always_comb begin
      pready_d = access;
      pslverr_d = access && !mapped;
      prdata_d = 32'h0000_0000;
      if (access && !i_pwrite) begin
         unique case (i_paddr)
            `FPCC_ADDR_FLL_CTRL: prdata_d = {30'h0, fll_ctrl_q};
            `FPCC_ADDR_PLL_CTRLB: prdata_d = {27'h0, pll_ctrlb_q};
            `FPCC_ADDR_PLL_RATIO: prdata_d = {16'h0, ratio_q};
            `FPCC_ADDR_IRQ_FLAGS: prdata_d = {26'h0, flags_q};
            `FPCC_ADDR_PLL_STATUS: prdata_d = {29'h0, timed_out_q, clk_en_q, lock_q};
            `FPCC_ADDR_XOSC_CTRL: prdata_d = {31'h0, aamp_q};
            `FPCC_ADDR_PWR_STATUS: prdata_d = {30'h0, fine_q, coarse_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Control registers and ratio tracker
   always_comb begin
      fll_ctrl_d = fll_ctrl_q;
      pll_ctrlb_d = pll_ctrlb_q;
      ratio_d = ratio_q;
      aamp_d = aamp_q;
      rst_d = rst_q;
      if (wr && i_paddr == `FPCC_ADDR_FLL_CTRL) begin
         fll_ctrl_d = i_pwdata[1:0];
      end
      if (wr && i_paddr == `FPCC_ADDR_PLL_CTRLB) begin
         pll_ctrlb_d = i_pwdata[4:0];
      end
      if (wr && i_paddr == `FPCC_ADDR_XOSC_CTRL) begin
         aamp_d = i_pwdata[`FPCC_AAMP_BIT];
      end
      unique case (rst_q)
         fpcc_pkg::FPCC_RATIO_IDLE: begin
            if (i_pll_ratio_applied) begin
               rst_d = fpcc_pkg::FPCC_RATIO_IDLE;
            end
         end
         fpcc_pkg::FPCC_RATIO_WAIT: begin
            // wait for the loop to take the ratio
            if (i_pll_ratio_applied) begin
               rst_d = fpcc_pkg::FPCC_RATIO_IDLE;
            end
         end
      endcase
      if (wr && i_paddr == `FPCC_ADDR_PLL_RATIO) begin
         ratio_d = i_pwdata[`FPCC_RATIO_W-1:0];
         if (pll_ctrlb_q[`FPCC_PLL_EN_BIT]) begin
            rst_d = fpcc_pkg::FPCC_RATIO_WAIT;
         end
      end
      if (!pll_ctrlb_q[`FPCC_PLL_EN_BIT]) begin
         rst_d = fpcc_pkg::FPCC_RATIO_IDLE;
      end
   end

   // Status tracking and sticky flags
   always_comb begin
      lock_d = i_pll_lock;
      coarse_d = i_fll_coarse_lock;
      fine_d = i_fll_fine_lock;
      timed_out_d = pll_ctrlb_q[`FPCC_PLL_EN_BIT] && (timed_out_q || tif.timeout);
      // gate closed while lock is absent; bypass opens it
      clk_en_d = pll_ctrlb_q[`FPCC_PLL_EN_BIT] &&
                 (i_pll_lock || pll_ctrlb_q[`FPCC_BYPASS_BIT]);
      set = '0;
      set[`FPCC_IRQ_FLL_COARSE] = i_fll_coarse_lock && !coarse_q;
      set[`FPCC_IRQ_FLL_FINE] = i_fll_fine_lock && !fine_q;
      set[`FPCC_IRQ_FLL_OOB] = i_fll_locking &&
         (at_limit({4'h0, i_fll_coarse}, {4'h0, `FPCC_COARSE_MAX}) ||
          at_limit(i_fll_fine, `FPCC_FINE_MAX));
      // rise flag on lock gain; both flags on lock loss
      set[`FPCC_IRQ_LOCK_RISE] = (i_pll_lock != lock_q);
      set[`FPCC_IRQ_LOCK_FALL] = !i_pll_lock && lock_q;
      // done flag when the new ratio is in effect
      set[`FPCC_IRQ_RATIO_DONE] = (rst_q == fpcc_pkg::FPCC_RATIO_WAIT) && i_pll_ratio_applied;
      clr = (wr && i_paddr == `FPCC_ADDR_IRQ_FLAGS) ? i_pwdata[`FPCC_IRQ_W-1:0] : '0;
      // Set wins over a clear in the same cycle
      flags_d = (flags_q & ~clr) | set;
   end

   // All registers
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         fll_ctrl_q <= `FPCC_FLL_CTRL_RST;
         pll_ctrlb_q <= `FPCC_PLL_CTRLB_RST;
         ratio_q <= `FPCC_RATIO_RST;
         flags_q <= '0;
         aamp_q <= 1'b0;
         lock_q <= 1'b0;
         coarse_q <= 1'b0;
         fine_q <= 1'b0;
         timed_out_q <= 1'b0;
         clk_en_q <= 1'b0;
         rst_q <= fpcc_pkg::FPCC_RATIO_IDLE;
      end else begin
         pready_q <= pready_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         fll_ctrl_q <= fll_ctrl_d;
         pll_ctrlb_q <= pll_ctrlb_d;
         ratio_q <= ratio_d;
         flags_q <= flags_d;
         aamp_q <= aamp_d;
         lock_q <= lock_d;
         coarse_q <= coarse_d;
         fine_q <= fine_d;
         timed_out_q <= timed_out_d;
         clk_en_q <= clk_en_d;
         rst_q <= rst_d;
      end
   end

   // Outputs straight from flops
   assign o_pready = pready_q;
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q;
   assign o_pll_enable = pll_ctrlb_q[`FPCC_PLL_EN_BIT];
   assign o_pll_clk_en = clk_en_q;
   assign o_pll_ratio = ratio_q;
   assign o_fll_enable = fll_ctrl_q[`FPCC_FLL_EN_BIT];
   assign o_fll_on_request_run = fll_ctrl_q[`FPCC_FLL_ONREQ_BIT];
   assign o_auto_amplitude_en = aamp_q;

   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_fall_sets_flags: assert property (
      lock_q && !i_pll_lock |=> flags_q[`FPCC_IRQ_LOCK_FALL] && flags_q[`FPCC_IRQ_LOCK_RISE])
      else $error("Lock loss did not raise both flags");
   a_fall_masks_clock: assert property (
      !i_pll_lock && !pll_ctrlb_q[`FPCC_BYPASS_BIT] |=> !o_pll_clk_en)
      else $error("Clock not masked without lock");
   a_bypass_passes_clock: assert property (
      pll_ctrlb_q[`FPCC_BYPASS_BIT] && pll_ctrlb_q[`FPCC_PLL_EN_BIT] |=> o_pll_clk_en)
      else $error("Bypass did not pass the clock");
   a_ratio_done_flag: assert property (
      rst_q == fpcc_pkg::FPCC_RATIO_WAIT && i_pll_ratio_applied |=> flags_q[`FPCC_IRQ_RATIO_DONE])
      else $error("Ratio done flag missing");
   a_oob_on_limit: assert property (
      i_fll_locking && i_fll_fine == `FPCC_FINE_MAX |=> flags_q[`FPCC_IRQ_FLL_OOB])
      else $error("Out-of-bounds flag missing");
   a_lock_rise_flag: assert property (
      $rose(i_pll_lock) |=> lock_q && flags_q[`FPCC_IRQ_LOCK_RISE])
      else $error("Lock gain not reflected");
   a_apb_answer: assert property (
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
      else $error("APB answer not one cycle");

   c_ratio_update: cover property (rst_q == fpcc_pkg::FPCC_RATIO_WAIT ##[1:20] !rst_q);
   c_lock_lost: cover property (lock_q ##1 !lock_q);
   c_bad_addr: cover property (o_pslverr);
endmodule : fpcc_clock_ctrl
`default_nettype wire

// ==== fpcc_clock_ctrl_tb.sv ====
/*
 * Self-checking bench of the clock-generation control block over APB.
 * Assumes the design files are compiled first; assertions sit in them.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpcc_params.svh"
module fpcc_clock_ctrl_tb;
   localparam int unsigned SHORT = 20; // Shortened short time-out
   localparam int unsigned LONG = 30;  // Shortened long time-out
   logic i_clock = 1'b0; // Bench clock
   logic i_rst = 1'b1; // Reset, active high
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
   logic [7:0] paddr = 8'h00; // APB address
   logic [31:0] pwdata = 32'h00000000; // APB write data
   logic pready, pslverr; // APB answer
   logic [31:0] prdata; // APB read data
   logic lock = 1'b0, applied = 1'b0, locking = 1'b0; // Loop status
   logic c_lock = 1'b0, f_lock = 1'b0; // Calibration lock levels
   logic [5:0] coarse = 6'h20; // Coarse calibration
   logic [9:0] fine = 10'h200; // Fine calibration
   logic pll_en, clk_en, fll_en, onreq, aamp; // Control outputs
   logic [15:0] ratio; // Ratio to the loop
   int bad_count = 0, checks = 0, cyc = 0; // Counters
   logic [31:0] rd; // Scratch read data
   logic er; // Scratch error bit
   fpcc_clock_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) fpcc_clock_ctrl_i (
      .i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_pll_lock(lock),
      .i_pll_ratio_applied(applied), .i_fll_locking(locking),
      .i_fll_coarse_lock(c_lock), .i_fll_fine_lock(f_lock), .i_fll_coarse(coarse),
      .i_fll_fine(fine), .o_pll_enable(pll_en), .o_pll_clk_en(clk_en),
      .o_pll_ratio(ratio), .o_fll_enable(fll_en), .o_fll_on_request_run(onreq),
      .o_auto_amplitude_en(aamp));
   // Clock of 10 ns
   always #5 i_clock = ~i_clock;
   // Hang guard
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         print_verdict();
      end
   end
   // Expected gate of the loop clock
   function automatic logic gate_exp(input logic en, input logic lk, input logic byp);
      return en & (lk | byp);
   endfunction : gate_exp
   // Expected time-out figure of a selector, zero when none
   function automatic int unsigned to_exp(input logic [2:0] sel);
      return (sel < 3'h4) ? 0 : ((sel < 3'h6) ? SHORT : LONG);
   endfunction : to_exp
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks = checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // One APB transfer; waits for ready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge i_clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n == 20) chk(32'h0, 32'h1, "ready wait");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      // Let the committing edge pass so outputs show the written value
      @(posedge i_clock);
   endtask : wr
   task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, what);
   endtask : rdx
   // Closing report
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial begin
      logic [15:0] rv;
      void'($urandom(32'h4611));
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      // Reset values and a refused address
      chk({onreq, pll_en, clk_en, aamp}, 32'h8, "reset outputs");
      rdx(`FPCC_ADDR_FLL_CTRL, 32'h2, "fll ctrl reset");
      rdx(`FPCC_ADDR_PLL_CTRLB, 32'h0, "ctrlb reset");
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h0, "flags reset");
      apb(1'b0, 8'h1C, 32'h0, rd, er);
      chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
      wr(`FPCC_ADDR_FLL_CTRL, 32'h0);
      chk(onreq, 1'b0, "on request cleared");
      wr(`FPCC_ADDR_FLL_CTRL, 32'h1);
      chk({fll_en, onreq}, 2'h2, "fll enabled");
      // Amplitude control follows the register, on then off
      wr(`FPCC_ADDR_XOSC_CTRL, 32'h1);
      chk(aamp, 1'b1, "amp on");
      wr(`FPCC_ADDR_XOSC_CTRL, 32'h0);
      chk(aamp, 1'b0, "amp off");
      for (int s = 0; s < 8; s++) begin
         wr(`FPCC_ADDR_PLL_CTRLB, 32'h10 | s);
         repeat (22) @(posedge i_clock);
         rdx(`FPCC_ADDR_PLL_STATUS, (to_exp(3'(s)) == SHORT) ? 32'h4 : 32'h0, "early");
         repeat (12) @(posedge i_clock);
         rdx(`FPCC_ADDR_PLL_STATUS, (to_exp(3'(s)) != 0) ? 32'h4 : 32'h0, "late");
         wr(`FPCC_ADDR_PLL_CTRLB, 32'h0);
      end
      // Lock gain, lock loss with masking
      wr(`FPCC_ADDR_IRQ_FLAGS, 32'h3F);
      wr(`FPCC_ADDR_PLL_CTRLB, 32'h10);
      chk(pll_en, 1'b1, "pll enabled");
      @(posedge i_clock);
      lock <= 1'b1;
      repeat (3) @(posedge i_clock);
      chk(clk_en, gate_exp(1'b1, 1'b1, 1'b0), "gate on lock");
      rdx(`FPCC_ADDR_PLL_STATUS, 32'h3, "status locked");
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h08, "rise flag");
      wr(`FPCC_ADDR_IRQ_FLAGS, 32'h08);
      lock <= 1'b0;
      repeat (3) @(posedge i_clock);
      chk(clk_en, gate_exp(1'b1, 1'b0, 1'b0), "masked");
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h18, "fall flags");
      wr(`FPCC_ADDR_IRQ_FLAGS, 32'h18);
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h0, "flags cleared");
      // Bypass passes the clock while unlocked
      wr(`FPCC_ADDR_PLL_CTRLB, 32'h18);
      repeat (2) @(posedge i_clock);
      chk(clk_en, gate_exp(1'b1, 1'b0, 1'b1), "bypass gate");
      // Ratio loads while running, random values
      for (int k = 0; k < 3; k++) begin
         rv = 16'($urandom());
         wr(`FPCC_ADDR_PLL_RATIO, {16'h0, rv});
         chk(ratio, rv, "ratio out");
         rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h0, "done not yet");
         applied <= 1'b1;
         @(posedge i_clock);
         applied <= 1'b0;
         repeat (2) @(posedge i_clock);
         rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h20, "ratio done");
         wr(`FPCC_ADDR_IRQ_FLAGS, 32'h20);
      end
      c_lock <= 1'b1;
      f_lock <= 1'b1;
      repeat (2) @(posedge i_clock);
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h03, "lock flags");
      rdx(`FPCC_ADDR_PWR_STATUS, 32'h3, "power status");
      wr(`FPCC_ADDR_IRQ_FLAGS, 32'h03);
      locking <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         coarse <= 6'($urandom_range(1, 62));
         fine <= 10'($urandom_range(1, 1022));
         @(posedge i_clock);
      end
      rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h0, "no bounds");
      for (int k = 0; k < 4; k++) begin
         coarse <= (k == 0) ? 6'h00 : ((k == 1) ? `FPCC_COARSE_MAX : 6'h20);
         fine <= (k == 2) ? 10'h000 : ((k == 3) ? `FPCC_FINE_MAX : 10'h200);
         @(posedge i_clock);
         coarse <= 6'h20;
         fine <= 10'h200;
         repeat (2) @(posedge i_clock);
         rdx(`FPCC_ADDR_IRQ_FLAGS, 32'h04, "bounds flag");
         wr(`FPCC_ADDR_IRQ_FLAGS, 32'h04);
      end
      locking <= 1'b0;
      print_verdict();
   end
endmodule : fpcc_clock_ctrl_tb
`default_nettype wire
